// >>> hdl/bsp_pkg.sv
// constants and types for the bus strobe pin logic
// assumes a single 100 MHz clock and an axi4-lite register port
package bsp_pkg;

  localparam int           ADDR_W       = 4;
  localparam logic [3:0]   CTRL_OFS     = 4'h0;
  localparam logic [3:0]   STATUS_OFS   = 4'h4;

  localparam int           CTRL_W       = 9;
  localparam int           CTRL_PIN3_SEL = 0;
  localparam int           CTRL_PIN2_SEL = 1;
  localparam int           CTRL_IO_DIR  = 2;
  localparam int           CTRL_EDE_DIR = 4;
  localparam int           CTRL_MEM_DIR = 6;
  localparam int           CTRL_RET_EN  = 8;
  localparam logic [8:0]   CTRL_RST     = 9'h000;

  localparam int           DIR_RD       = 0;
  localparam int           DIR_WR       = 1;

  localparam int           STAT_COND2   = 0;
  localparam int           STAT_COND3   = 1;
  localparam int           STAT_GRANT   = 2;
  localparam int           STAT_REQ     = 3;
  localparam int           STAT_BUSY    = 4;
  localparam int           STAT_WDRAW   = 5;

  localparam logic [3:0]   SYNC_RST     = 4'h1;
  localparam logic [1:0]   RESP_OKAY    = 2'h0;
  localparam logic [1:0]   RESP_SLVERR  = 2'h2;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_ADDR,
    SEQ_DATA
  } bsp_seq_t;

endpackage : bsp_pkg

// >>> hdl/bsp_phase_if.sv
// bus transfer phase signals passed to the strobe generator
// assumes all members are driven from flops on mclk_i
`timescale 1ns/1ns
interface bsp_phase_if;
  logic data;
  logic first;
  logic dstart;
  logic wr;

  modport src (output data, output first, output dstart, output wr);
  modport dst (input data, input first, input dstart, input wr);
endinterface : bsp_phase_if

// >>> hdl/bsp_sync.sv
// two-stage synchroniser for asynchronous pins
// assumes the inputs come from outside the mclk_i domain
`timescale 1ns/1ns
module bsp_sync #(
  parameter int               WIDTH   = 4,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;

  always_comb
  begin
    next_meta = d_i;
    next_q    = meta;
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      meta <= RST_VAL;
      q_o  <= RST_VAL;
    end
    else
    begin
      meta <= next_meta;
      q_o  <= next_q;
    end
  end

endmodule : bsp_sync

// >>> hdl/bsp_strobe_gen.sv
// io strobe, extended data enable and memory strobe generation
// assumes phase signals are registered on mclk_i by the sequencer
`timescale 1ns/1ns
module bsp_strobe_gen (
  input  wire logic       mclk_i,
  input  wire logic       nrst_i,
  bsp_phase_if.dst        ph,
  input  wire logic [1:0] io_dir_i,
  input  wire logic [1:0] ede_dir_i,
  input  wire logic [1:0] mem_dir_i,
  output logic            io_n_o,
  output logic            ede_n_o,
  output logic            mem_n_o
);

  logic io_hit;
  logic ede_hit;
  logic mem_hit;
  logic ede_on;
  logic tail;
  logic next_tail;

  always_comb
  begin
    io_hit  = ph.wr ? io_dir_i[bsp_pkg::DIR_WR]  : io_dir_i[bsp_pkg::DIR_RD];
    ede_hit = ph.wr ? ede_dir_i[bsp_pkg::DIR_WR] : ede_dir_i[bsp_pkg::DIR_RD];
    mem_hit = ph.wr ? mem_dir_i[bsp_pkg::DIR_WR] : mem_dir_i[bsp_pkg::DIR_RD];
    ede_on  = ph.data && ede_hit;
    next_tail = ede_on;
    io_n_o  = !(ph.first && io_hit);
    mem_n_o = !(ph.dstart && mem_hit);
    ede_n_o = !(ede_on || tail);
  end

  // sampled mid-cycle, so it outlasts the strobe by half a cycle
  always_ff @(negedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      tail <= 1'b0;
    else
      tail <= next_tail;
  end

endmodule : bsp_strobe_gen

// >>> hdl/bsp_top.sv
// dual-function bus pin logic: arbitration, transfer phases, strobes
// assumes core requests on mclk_i and asynchronous pins from the board
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
// Contract
// - return protocol withdraws grant, waits request drop
// - control register selects each pin function
// - upper pin drives condition flag 3
// - lower pin drives condition flag 2
// - condition inputs pass two synchroniser stages
// - io strobe on reads, writes or both
// - io strobe asserts in transfer second cycle
// - data enable on reads, writes or both
// - data enable holds half cycle after strobe
// - memory strobe pulses low once per datum
// - bus request floats outputs, drop returns bus
// - write indication high throughout write transfers
module bsp_top #(
  parameter int LEN_W = 2
) (
  input  wire logic                      mclk_i,
  input  wire logic                      nrst_i,
  input  wire logic [bsp_pkg::ADDR_W-1:0] awaddr_i,
  input  wire logic                      awvalid_i,
  output logic                           awready_o,
  input  wire logic [31:0]               wdata_i,
  input  wire logic [3:0]                wstrb_i,
  input  wire logic                      wvalid_i,
  output logic                           wready_o,
  output logic [1:0]                     bresp_o,
  output logic                           bvalid_o,
  input  wire logic                      bready_i,
  input  wire logic [bsp_pkg::ADDR_W-1:0] araddr_i,
  input  wire logic                      arvalid_i,
  output logic                           arready_o,
  output logic [31:0]                    rdata_o,
  output logic [1:0]                     rresp_o,
  output logic                           rvalid_o,
  input  wire logic                      rready_i,
  input  wire logic                      xfer_valid_i,
  output logic                           xfer_ready_o,
  input  wire logic                      xfer_write_i,
  input  wire logic [LEN_W-1:0]          xfer_len_i,
  output logic                           xfer_done_o,
  output logic [3:2]                     cop_cond_flag_o,
  input  wire logic                      bus_request_in_i,
  output logic                           bus_grant_out_o,
  output logic                           bus_oe_o,
  input  wire logic                      ack_n_i,
  output logic                           rd_strobe_n_o,
  output logic                           wr_strobe_n_o,
  output logic                           write_ind_o,
  output logic                           memory_cycle_strobe_n_o,
  input  wire logic                      cond3_pin_i,
  output logic                           cond3_pin_o,
  output logic                           cond3_pin_oe_o,
  input  wire logic                      cond2_pin_i,
  output logic                           cond2_pin_o,
  output logic                           cond2_pin_oe_o
);

  logic [3:0]                  sync_q;
  logic                        c3_s;
  logic                        c2_s;
  logic                        req_s;
  logic                        ack_s;

  logic [bsp_pkg::CTRL_W-1:0]  ctrl;
  logic [bsp_pkg::CTRL_W-1:0]  next_ctrl;

  logic                        aw_hold;
  logic                        next_aw_hold;
  logic [bsp_pkg::ADDR_W-1:0]  aw_addr;
  logic [bsp_pkg::ADDR_W-1:0]  next_aw_addr;
  logic                        w_hold;
  logic                        next_w_hold;
  logic [31:0]                 w_data;
  logic [31:0]                 next_w_data;
  logic [3:0]                  w_strb;
  logic [3:0]                  next_w_strb;
  logic                        bvalid;
  logic                        next_bvalid;
  logic [1:0]                  bresp;
  logic [1:0]                  next_bresp;
  logic                        do_write;

  logic                        rvalid;
  logic                        next_rvalid;
  logic [31:0]                 rdata;
  logic [31:0]                 next_rdata;
  logic [1:0]                  rresp;
  logic [1:0]                  next_rresp;
  logic [31:0]                 status;

  bsp_pkg::bsp_seq_t           state;
  bsp_pkg::bsp_seq_t           next_state;
  logic [LEN_W-1:0]            left;
  logic [LEN_W-1:0]            next_left;
  logic                        wr_q;
  logic                        next_wr;
  logic                        grant;
  logic                        next_grant;
  logic                        withdraw;
  logic                        next_withdraw;
  logic                        done;
  logic                        next_done;
  logic                        first;
  logic                        next_first;
  logic                        dstart;
  logic                        next_dstart;
  logic                        accept;
  logic                        own;

  logic                        io_n;
  logic                        ede_n;

  bsp_phase_if u_ph ();

  // pins from the board
  bsp_sync #(
    .WIDTH   (4),
    .RST_VAL (bsp_pkg::SYNC_RST)
  ) u_sync (
    .clk_i  (mclk_i),
    .nrst_i (nrst_i),
    .d_i    ({cond3_pin_i, cond2_pin_i, bus_request_in_i, ack_n_i}),
    .q_o    (sync_q)
  );

  assign c3_s  = sync_q[3];
  assign c2_s  = sync_q[2];
  assign req_s = sync_q[1];
  assign ack_s = !sync_q[0];

  // axi write channel and control register
  always_comb
  begin
    next_aw_hold = aw_hold;
    next_aw_addr = aw_addr;
    next_w_hold  = w_hold;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_ctrl    = ctrl;
    do_write     = aw_hold && w_hold && !bvalid;
    if (awvalid_i && awready_o)
    begin
      next_aw_hold = 1'b1;
      next_aw_addr = awaddr_i;
    end
    if (wvalid_i && wready_o)
    begin
      next_w_hold = 1'b1;
      next_w_data = wdata_i;
      next_w_strb = wstrb_i;
    end
    if (do_write)
    begin
      next_aw_hold = 1'b0;
      next_w_hold  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = bsp_pkg::RESP_OKAY;
      case (aw_addr)
        bsp_pkg::CTRL_OFS:
        begin
          if (w_strb[0])
            next_ctrl[7:0] = w_data[7:0];
          if (w_strb[1])
            next_ctrl[8] = w_data[8];
        end
        bsp_pkg::STATUS_OFS:
          next_bresp = bsp_pkg::RESP_OKAY;
        default:
          next_bresp = bsp_pkg::RESP_SLVERR;
      endcase
    end
    if (bvalid && bready_i)
      next_bvalid = 1'b0;
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      aw_hold <= 1'b0;
      aw_addr <= '0;
      w_hold  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= bsp_pkg::RESP_OKAY;
      ctrl    <= bsp_pkg::CTRL_RST;
    end
    else
    begin
      aw_hold <= next_aw_hold;
      aw_addr <= next_aw_addr;
      w_hold  <= next_w_hold;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      ctrl    <= next_ctrl;
    end
  end

  assign awready_o = !aw_hold && !bvalid;
  assign wready_o  = !w_hold && !bvalid;
  assign bvalid_o  = bvalid;
  assign bresp_o   = bresp;

  // axi read channel
  always_comb
  begin
    status = 32'h0000_0000;
    status[bsp_pkg::STAT_COND2] = cop_cond_flag_o[2];
    status[bsp_pkg::STAT_COND3] = cop_cond_flag_o[3];
    status[bsp_pkg::STAT_GRANT] = grant;
    status[bsp_pkg::STAT_REQ]   = req_s;
    status[bsp_pkg::STAT_BUSY]  = (state != bsp_pkg::SEQ_IDLE);
    status[bsp_pkg::STAT_WDRAW] = withdraw;
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (arvalid_i && arready_o)
    begin
      next_rvalid = 1'b1;
      next_rresp  = bsp_pkg::RESP_OKAY;
      case (araddr_i)
        bsp_pkg::CTRL_OFS:
          next_rdata = {23'h000000, ctrl};
        bsp_pkg::STATUS_OFS:
          next_rdata = status;
        default:
        begin
          next_rdata = 32'h0000_0000;
          next_rresp = bsp_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid && rready_i)
      next_rvalid = 1'b0;
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= bsp_pkg::RESP_OKAY;
    end
    else
    begin
      rvalid <= next_rvalid;
      rdata  <= next_rdata;
      rresp  <= next_rresp;
    end
  end

  assign arready_o = !rvalid;
  assign rvalid_o  = rvalid;
  assign rdata_o   = rdata;
  assign rresp_o   = rresp;

  // transfer sequencer and bus arbitration
  always_comb
  begin
    next_state    = state;
    next_left     = left;
    next_wr       = wr_q;
    next_grant    = grant;
    next_withdraw = withdraw;
    next_done     = 1'b0;
    next_first    = 1'b0;
    next_dstart   = 1'b0;
    accept = (state == bsp_pkg::SEQ_IDLE) && xfer_valid_i && !grant && !withdraw && !req_s;
    case (state)
      bsp_pkg::SEQ_IDLE:
      begin
        if (accept)
        begin
          next_state = bsp_pkg::SEQ_ADDR;
          next_left  = xfer_len_i;
          next_wr    = xfer_write_i;
        end
      end
      bsp_pkg::SEQ_ADDR:
      begin
        next_state  = bsp_pkg::SEQ_DATA;
        next_first  = 1'b1;
        next_dstart = 1'b1;
      end
      bsp_pkg::SEQ_DATA:
      begin
        if (ack_s)
        begin
          if (left == '0)
          begin
            next_state = bsp_pkg::SEQ_IDLE;
            next_done  = 1'b1;
            next_wr    = 1'b0;
          end
          else
          begin
            next_left   = left - 1'b1;
            next_dstart = 1'b1;
          end
        end
      end
      default:
        next_state = bsp_pkg::SEQ_IDLE;
    endcase
    if (grant)
    begin
      if (!req_s)
        next_grant = 1'b0;
      else if (ctrl[bsp_pkg::CTRL_RET_EN] && xfer_valid_i)
      begin
        next_grant    = 1'b0;
        next_withdraw = 1'b1;
      end
    end
    else if (withdraw)
    begin
      if (!req_s)
        next_withdraw = 1'b0;
    end
    else if (req_s && state == bsp_pkg::SEQ_IDLE)
      next_grant = 1'b1;
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state    <= bsp_pkg::SEQ_IDLE;
      left     <= '0;
      wr_q     <= 1'b0;
      grant    <= 1'b0;
      withdraw <= 1'b0;
      done     <= 1'b0;
      first    <= 1'b0;
      dstart   <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      left     <= next_left;
      wr_q     <= next_wr;
      grant    <= next_grant;
      withdraw <= next_withdraw;
      done     <= next_done;
      first    <= next_first;
      dstart   <= next_dstart;
    end
  end

  assign xfer_ready_o = accept;
  assign xfer_done_o  = done;
  assign own          = !grant && !withdraw;

  assign u_ph.data   = (state == bsp_pkg::SEQ_DATA);
  assign u_ph.first  = first;
  assign u_ph.dstart = dstart;
  assign u_ph.wr     = wr_q;

  bsp_strobe_gen u_gen (
    .mclk_i    (mclk_i),
    .nrst_i    (nrst_i),
    .ph        (u_ph),
    .io_dir_i  (ctrl[bsp_pkg::CTRL_IO_DIR +: 2]),
    .ede_dir_i (ctrl[bsp_pkg::CTRL_EDE_DIR +: 2]),
    .mem_dir_i (ctrl[bsp_pkg::CTRL_MEM_DIR +: 2]),
    .io_n_o    (io_n),
    .ede_n_o   (ede_n),
    .mem_n_o   (memory_cycle_strobe_n_o)
  );

  // pin outputs
  assign bus_grant_out_o = grant;
  assign bus_oe_o        = own;
  assign write_ind_o     = wr_q;
  assign rd_strobe_n_o   = !(u_ph.data && !wr_q);
  assign wr_strobe_n_o   = !(u_ph.data && wr_q);
  assign cond3_pin_o     = io_n;
  assign cond2_pin_o     = ede_n;
  assign cond3_pin_oe_o  = ctrl[bsp_pkg::CTRL_PIN3_SEL] && own;
  assign cond2_pin_oe_o  = ctrl[bsp_pkg::CTRL_PIN2_SEL] && own;
  assign cop_cond_flag_o[3] = ctrl[bsp_pkg::CTRL_PIN3_SEL] ? 1'b0 : c3_s;
  assign cop_cond_flag_o[2] = ctrl[bsp_pkg::CTRL_PIN2_SEL] ? 1'b0 : c2_s;

endmodule : bsp_top

// >>> verification/bsp_top_asserts.sv
// checker on the ports of the bus strobe pin logic
// assumes it is bound into bsp_top and sees only its ports
`timescale 1ns/1ns
module bsp_top_asserts #(
  parameter int LEN_W = 2
) (
  input wire logic       mclk_i,
  input wire logic       nrst_i,
  input wire logic       xfer_valid_i,
  input wire logic       xfer_ready_o,
  input wire logic [3:2] cop_cond_flag_o,
  input wire logic       bus_request_in_i,
  input wire logic       bus_grant_out_o,
  input wire logic       bus_oe_o,
  input wire logic       rd_strobe_n_o,
  input wire logic       wr_strobe_n_o,
  input wire logic       write_ind_o,
  input wire logic       memory_cycle_strobe_n_o,
  input wire logic       cond3_pin_i,
  input wire logic       cond3_pin_o,
  input wire logic       cond3_pin_oe_o,
  input wire logic       cond2_pin_i,
  input wire logic       cond2_pin_o,
  input wire logic       cond2_pin_oe_o
);
  logic idle;
  assign idle = rd_strobe_n_o && wr_strobe_n_o;
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);
  sequence s_ede_tail;
    !cond2_pin_o ##1 cond2_pin_o;
  endsequence
  sequence s_req_low;
    !bus_request_in_i [*3];
  endsequence
  sequence s_branch3;
    (bus_oe_o && !cond3_pin_oe_o) [*3];
  endsequence
  sequence s_branch2;
    (bus_oe_o && !cond2_pin_oe_o) [*3];
  endsequence
  io_second_a: assert property ((cond3_pin_oe_o && !cond3_pin_o) |->
    $past(xfer_valid_i, 2) && $past(xfer_ready_o, 2)) else $error("io strobe off second cycle");
  io_in_data_a: assert property ((cond3_pin_oe_o && !cond3_pin_o) |-> !idle)
    else $error("io strobe outside transfer");
  mem_pulse_a: assert property ($fell(memory_cycle_strobe_n_o) |=> memory_cycle_strobe_n_o)
    else $error("memory strobe pulse too long");
  mem_in_data_a: assert property (!memory_cycle_strobe_n_o |-> !idle)
    else $error("memory strobe outside transfer");
  ede_tail_a: assert property (@(negedge mclk_i)
    (cond2_pin_oe_o && $rose(idle) && !$past(cond2_pin_o)) |-> s_ede_tail)
    else $error("data enable tail wrong");
  write_ind_a: assert property (!idle |-> write_ind_o == !wr_strobe_n_o)
    else $error("write indication wrong");
  flag3_sync_a: assert property (s_branch3 ##0 $past(nrst_i, 2) |->
    cop_cond_flag_o[3] == $past(cond3_pin_i, 2)) else $error("flag 3 not synced pin");
  flag2_sync_a: assert property (s_branch2 ##0 $past(nrst_i, 2) |->
    cop_cond_flag_o[2] == $past(cond2_pin_i, 2)) else $error("flag 2 not synced pin");
  strobe_flag_a: assert property ((cond3_pin_oe_o || cond2_pin_oe_o) |->
    !(cond3_pin_oe_o && cop_cond_flag_o[3]) && !(cond2_pin_oe_o && cop_cond_flag_o[2]))
    else $error("flag active in strobe mode");
  grant_float_a: assert property (bus_grant_out_o |-> !bus_oe_o && idle)
    else $error("bus driven while granted");
  grant_cause_a: assert property (s_req_low |=> !$rose(bus_grant_out_o))
    else $error("grant without request");
  withdraw_wait_a: assert property ((!bus_grant_out_o && !bus_oe_o) |-> idle && !xfer_ready_o)
    else $error("bus taken back early");
  return_cause_a: assert property ($rose(bus_oe_o) |-> !$past(bus_request_in_i, 2))
    else $error("bus retaken with request up");
endmodule : bsp_top_asserts
bind bsp_top bsp_top_asserts #(.LEN_W(LEN_W)) u_bsp_chk (.mclk_i, .nrst_i, .xfer_valid_i,
  .xfer_ready_o, .cop_cond_flag_o, .bus_request_in_i, .bus_grant_out_o, .bus_oe_o, .rd_strobe_n_o,
  .wr_strobe_n_o, .write_ind_o, .memory_cycle_strobe_n_o, .cond3_pin_i, .cond3_pin_o,
  .cond3_pin_oe_o, .cond2_pin_i, .cond2_pin_o, .cond2_pin_oe_o);

// >>> verification/bsp_far_model.sv
// external bus master and memory device at the far side
// assumes the bench commands the master through req_on_i
`timescale 1ns/1ns
module bsp_far_model (
  input  wire logic       mclk_i,
  input  wire logic       nrst_i,
  input  wire logic       req_on_i,
  input  wire logic [1:0] ack_wait_i,
  input  wire logic       grant_i,
  input  wire logic       own_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  output logic            req_o,
  output logic            ack_n_o
);
  logic       on_q;
  logic       gnt_q;
  logic [2:0] cnt;
  always @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      on_q <= 1'h0;
      gnt_q <= 1'h0;
      req_o <= 1'h0;
      ack_n_o <= 1'h1;
      cnt <= 3'h0;
    end
    else
    begin
      on_q <= req_on_i;
      gnt_q <= grant_i;
      // ask once per command, give up on early grant drop
      if (req_on_i && !on_q)
        req_o <= 1'h1;
      else if (!req_on_i || (gnt_q && !grant_i))
        req_o <= 1'h0;
      // one ack pulse per datum after a wait, pulled up otherwise
      ack_n_o <= !(own_i && !(rd_n_i && wr_n_i) && cnt == {1'h0, ack_wait_i});
      if (!own_i || (rd_n_i && wr_n_i) || cnt == {1'h0, ack_wait_i} + 3'h4)
        cnt <= 3'h0;
      else
        cnt <= cnt + 3'h1;
    end
  end
endmodule : bsp_far_model

// >>> verification/tb_bsp_top.sv
// self-checking bench for the bus strobe pin logic
// assumes bsp_top, the far side model and the bound checker
`timescale 1ns/1ns
module tb_bsp_top;
  logic        mclk_i = 1'h0, nrst_i = 1'h0;
  logic [3:0]  awaddr_i = 4'h0, araddr_i = 4'h0, wstrb_i = 4'h0;
  logic [31:0] wdata_i = 32'h0, seed = 32'h00013ccc;
  logic        awvalid_i = 1'h0, wvalid_i = 1'h0, bready_i = 1'h0, arvalid_i = 1'h0;
  logic        rready_i = 1'h0, xfer_valid_i = 1'h0, xfer_write_i = 1'h0;
  logic        req_on = 1'h0, p3 = 1'h0, p2 = 1'h0;
  logic [1:0]  xfer_len_i = 2'h0, ack_wait = 2'h0;
  wire logic   awready_o, wready_o, bvalid_o, arready_o, rvalid_o, xfer_ready_o, xfer_done_o;
  wire logic   bus_grant_out_o, bus_oe_o, rd_strobe_n_o, wr_strobe_n_o, write_ind_o;
  wire logic   memory_cycle_strobe_n_o, cond3_pin_o, cond3_pin_oe_o, cond2_pin_o, cond2_pin_oe_o;
  wire logic   bus_request_in_i, ack_n_i;
  wire logic [1:0]  bresp_o, rresp_o;
  wire logic [31:0] rdata_o;
  wire logic [3:2]  cop_cond_flag_o;
  wire logic   c3_w = cond3_pin_oe_o ? cond3_pin_o : p3;
  wire logic   c2_w = cond2_pin_oe_o ? cond2_pin_o : p2;
  int          error_cnt = 0, samples_checked = 0, cyc = 0, mem_n = 0, io_n = 0;
  logic        ede_seen = 1'h0, wr_bad = 1'h0, early = 1'h0, gnt_q = 1'h0;

  bsp_top #(.LEN_W(2)) uut (.mclk_i, .nrst_i, .awaddr_i, .awvalid_i, .awready_o, .wdata_i,
    .wstrb_i, .wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i, .araddr_i, .arvalid_i,
    .arready_o, .rdata_o, .rresp_o, .rvalid_o, .rready_i, .xfer_valid_i, .xfer_ready_o,
    .xfer_write_i, .xfer_len_i, .xfer_done_o, .cop_cond_flag_o, .bus_request_in_i,
    .bus_grant_out_o, .bus_oe_o, .ack_n_i, .rd_strobe_n_o, .wr_strobe_n_o, .write_ind_o,
    .memory_cycle_strobe_n_o, .cond3_pin_i(c3_w), .cond3_pin_o, .cond3_pin_oe_o,
    .cond2_pin_i(c2_w), .cond2_pin_o, .cond2_pin_oe_o);
  bsp_far_model u_far (.mclk_i, .nrst_i, .req_on_i(req_on), .ack_wait_i(ack_wait),
    .grant_i(bus_grant_out_o), .own_i(bus_oe_o), .rd_n_i(rd_strobe_n_o),
    .wr_n_i(wr_strobe_n_o), .req_o(bus_request_in_i), .ack_n_o(ack_n_i));

  always #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      error_cnt++;
      stop_test();
    end
  end
  // strobe and grant watchers
  always @(negedge mclk_i)
  begin
    if (!memory_cycle_strobe_n_o) mem_n++;
    if (cond3_pin_oe_o && !cond3_pin_o) io_n++;
    if (cond2_pin_oe_o && !cond2_pin_o) ede_seen = 1'h1;
    if (!rd_strobe_n_o && write_ind_o || !wr_strobe_n_o && !write_ind_o) wr_bad = 1'h1;
    if (gnt_q && !bus_grant_out_o && bus_request_in_i) early = 1'h1;
    gnt_q = bus_grant_out_o;
  end

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function int exp_cnt(input logic [1:0] dir, input logic w, input int per);
    return dir[w ? bsp_pkg::DIR_WR : bsp_pkg::DIR_RD] ? per : 0;
  endfunction : exp_cnt
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task stop_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test
  task axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic aw_t, w_t, b_t;
    @(posedge mclk_i);
    awaddr_i <= a;
    wdata_i <= d;
    wstrb_i <= s;
    awvalid_i <= 1'h1;
    wvalid_i <= 1'h1;
    bready_i <= 1'h1;
    b_t = 1'h0;
    while (!b_t)
    begin
      @(negedge mclk_i);
      aw_t = awvalid_i && awready_o;
      w_t = wvalid_i && wready_o;
      b_t = bvalid_o;
      if (b_t) chk(bresp_o, er);
      @(posedge mclk_i);
      if (aw_t) awvalid_i <= 1'h0;
      if (w_t) wvalid_i <= 1'h0;
      if (b_t) bready_i <= 1'h0;
    end
  endtask : axi_wr
  task axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar_t, r_t;
    @(posedge mclk_i);
    araddr_i <= a;
    arvalid_i <= 1'h1;
    rready_i <= 1'h1;
    r_t = 1'h0;
    while (!r_t)
    begin
      @(negedge mclk_i);
      ar_t = arvalid_i && arready_o;
      r_t = rvalid_o;
      if (r_t) chk({rdata_o, rresp_o}, {ed, er});
      @(posedge mclk_i);
      if (ar_t) arvalid_i <= 1'h0;
      if (r_t) rready_i <= 1'h0;
    end
  endtask : axi_rd
  task xfer(input logic w, input logic [1:0] n);
    logic hit;
    @(posedge mclk_i);
    xfer_valid_i <= 1'h1;
    xfer_write_i <= w;
    xfer_len_i <= n;
    hit = 1'h0;
    while (!hit)
    begin
      @(negedge mclk_i);
      hit = xfer_ready_o;
      @(posedge mclk_i);
    end
    xfer_valid_i <= 1'h0;
    hit = 1'h0;
    while (!hit)
    begin
      @(negedge mclk_i);
      hit = xfer_done_o;
    end
  endtask : xfer

  initial
  begin
    logic [1:0]  old;
    logic [31:0] t;
    repeat (12) @(posedge mclk_i);
    nrst_i <= 1'h1;
    axi_rd(bsp_pkg::CTRL_OFS, 32'h0, bsp_pkg::RESP_OKAY);
    axi_wr(bsp_pkg::CTRL_OFS, 32'hffffffff, 4'h1, bsp_pkg::RESP_OKAY);
    axi_rd(bsp_pkg::CTRL_OFS, 32'hff, bsp_pkg::RESP_OKAY);
    axi_wr(4'h8, rnd(), 4'hf, bsp_pkg::RESP_SLVERR);
    axi_rd(4'hc, 32'h0, bsp_pkg::RESP_SLVERR);
    axi_wr(bsp_pkg::CTRL_OFS, 32'h0, 4'h3, bsp_pkg::RESP_OKAY);
    $display("registers done");
    for (int i = 0; i < 6; i++)
    begin
      old = {p3, p2};
      t = rnd();
      @(posedge mclk_i);
      {p3, p2} <= t[1:0];
      repeat (2) @(negedge mclk_i);
      chk(cop_cond_flag_o, old);
      @(negedge mclk_i);
      chk(cop_cond_flag_o, t[1:0]);
      axi_rd(bsp_pkg::STATUS_OFS, {30'h0, t[1:0]}, bsp_pkg::RESP_OKAY);
    end
    $display("branch inputs done");
    for (int d = 0; d < 4; d++)
      for (int w = 0; w < 2; w++)
      begin
        t = rnd();
        axi_wr(bsp_pkg::CTRL_OFS, {24'h0, d[1:0], d[1:0], d[1:0], 2'h3}, 4'h3, bsp_pkg::RESP_OKAY);
        ack_wait <= t[3:2];
        mem_n = 0;
        io_n = 0;
        ede_seen = 1'h0;
        xfer(w[0], t[1:0]);
        repeat (2) @(negedge mclk_i);
        chk(mem_n, exp_cnt(d[1:0], w[0], int'(t[1:0]) + 1));
        chk(io_n, exp_cnt(d[1:0], w[0], 1));
        chk(ede_seen, exp_cnt(d[1:0], w[0], 1));
        chk(wr_bad, 1'h0);
        chk(cop_cond_flag_o, 2'h0);
      end
    $display("strobes done");
    @(posedge mclk_i);
    req_on <= 1'h1;
    xfer_write_i <= 1'h0;
    xfer_len_i <= 2'h0;
    repeat (6) @(posedge mclk_i);
    xfer_valid_i <= 1'h1;
    repeat (2) @(negedge mclk_i);
    chk({bus_grant_out_o, bus_oe_o, cond3_pin_oe_o, xfer_ready_o}, 4'h8);
    @(posedge mclk_i);
    req_on <= 1'h0;
    xfer(1'h0, 2'h0);
    chk({bus_grant_out_o, bus_oe_o}, 2'h1);
    $display("arbitration done");
    axi_wr(bsp_pkg::CTRL_OFS, 32'h1ff, 4'h3, bsp_pkg::RESP_OKAY);
    req_on <= 1'h1;
    repeat (6) @(negedge mclk_i);
    chk(bus_grant_out_o, 1'h1);
    early = 1'h0;
    xfer(1'h1, 2'h1);
    chk({early, bus_grant_out_o}, 2'h2);
    req_on <= 1'h0;
    $display("return protocol done");
    @(posedge mclk_i);
    nrst_i <= 1'h0;
    repeat (3) @(posedge mclk_i);
    nrst_i <= 1'h1;
    axi_rd(bsp_pkg::CTRL_OFS, 32'h0, bsp_pkg::RESP_OKAY);
    $display("second reset done");
    stop_test();
  end
endmodule : tb_bsp_top
